/* bench/ata_taskfile_error_address_regs_tb_top.sv */
// Self-checking bench for the taskfile error-cause, count and address registers.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin fails++; $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module ata_taskfile_error_address_regs_tb_top;
  logic                   sys_clk;
  logic                   reset;
  logic                   h2d_valid;
  atf_pkg::atf_h2d_t      h2d;
  logic                   cmd_supported;
  logic                   dev_not_ready;
  logic                   dev_write_fault;
  logic                   exec_sector_done;
  logic                   exec_done;
  atf_pkg::atf_exec_err_t exec_err;
  logic                   d2h_valid;
  atf_pkg::atf_d2h_t      d2h;
  logic                   cmd_start;
  logic [7:0]             cmd_opcode;
  logic                   busy;
  logic [8:0]             xfer_sectors;
  logic                   linear_mode;
  logic [27:0]            start_lba;
  logic [15:0]            chs_cylinder;
  logic [3:0]             chs_head;
  logic [7:0]             chs_sector;
  atf_pkg::atf_taskfile_t tf;
  int                     fails;
  int                     n_compared;
  int                     cycles;
  int                     starts;
  int                     snap;
  logic [7:0]             cause_exp [5] = '{8'h80, 8'h40, 8'h10, 8'h04, 8'h01};

  atf_host_model host (
    .sys_clk   (sys_clk),
    .h2d_valid (h2d_valid),
    .h2d       (h2d)
  );

  atf_error_address_regs #(.CNT_W(9)) uut (
    .sys_clk          (sys_clk),
    .reset            (reset),
    .h2d_valid        (h2d_valid),
    .h2d              (h2d),
    .cmd_supported    (cmd_supported),
    .dev_not_ready    (dev_not_ready),
    .dev_write_fault  (dev_write_fault),
    .exec_sector_done (exec_sector_done),
    .exec_done        (exec_done),
    .exec_err         (exec_err),
    .d2h_valid        (d2h_valid),
    .d2h              (d2h),
    .cmd_start        (cmd_start),
    .cmd_opcode       (cmd_opcode),
    .busy             (busy),
    .xfer_sectors     (xfer_sectors),
    .linear_mode      (linear_mode),
    .start_lba        (start_lba),
    .chs_cylinder     (chs_cylinder),
    .chs_head         (chs_head),
    .chs_sector       (chs_sector)
  );

  // Free-running 50 MHz clock.
  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;

  // Counts a start as soon as its pulse rises, so a snapshot taken after the pulse already holds it.
  always @(posedge cmd_start) begin
    starts++;
  end

  // Cuts a hang short.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      finish_test();
    end
  end

  // Prints the verdict and ends the run.
  task automatic finish_test();
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Polls the start pulse or the answer pulse for a few cycles.
  task automatic wait_out(input bit ans);
    int k;
    k = 0;
    while (((ans ? d2h_valid : cmd_start) !== 1'b1) && k < 8) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    `CHK(ans ? "answer" : "start", 1'b1, ans ? d2h_valid : cmd_start)
  endtask

  // One cycle of engine events, then all released.
  task automatic pulse(input logic sd, input logic dn, input atf_pkg::atf_exec_err_t er);
    @(posedge sys_clk);
    #1;
    exec_sector_done = sd;
    exec_done        = dn;
    exec_err         = er;
    @(posedge sys_clk);
    #1;
    exec_sector_done = 1'b0;
    exec_done        = 1'b0;
    exec_err         = '0;
  endtask

  initial begin
    reset = 1'b1;
    cmd_supported = 1'b1;
    dev_not_ready = 1'b0;
    dev_write_fault = 1'b0;
    exec_sector_done = 1'b0;
    exec_done = 1'b0;
    exec_err = '0;
    fails = 0;
    n_compared = 0;
    cycles = 0;
    starts = 0;
    repeat (5) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    // Linear command with a zero count, a frame while busy, then clean completion.
    tf = {8'h00, 8'h12, 8'h34, 8'h56, 8'hE9};
    host.send(1'b1, 8'h20, tf);
    wait_out(1'b0);
    `CHK("xfer", 9'h100, xfer_sectors)
    `CHK("linear", 1'b1, linear_mode)
    `CHK("lba", {4'h9, 8'h56, 8'h34, 8'h12}, start_lba)
    `CHK("busy", 1'b1, busy)
    `CHK("opcode", 8'h20, cmd_opcode)
    snap = starts;
    host.send(1'b1, 8'h20, tf);
    `CHK("ignored", snap, starts)
    repeat (3) pulse(1'b1, 1'b0, '0);
    pulse(1'b0, 1'b1, '0);
    wait_out(1'b1);
    `CHK("err", 1'b0, d2h.status.err)
    `CHK("ready", 1'b1, d2h.status.ready)
    `CHK("cause", 8'h00, d2h.error)
    `CHK("count", 8'h00, d2h.tf.count)
    `CHK("idle", 1'b0, busy)
    // Geometric commands, each failing with one error cause after two sectors.
    for (int i = 0; i < 5; i++) begin
      tf = {8'h05, 8'h21, 8'hC3, 8'h01, 4'hA, 4'(i)};
      host.send(1'b1, 8'h30, tf);
      wait_out(1'b0);
      `CHK("linear", 1'b0, linear_mode)
      `CHK("sector", 8'h21, chs_sector)
      `CHK("cyl", 16'h01C3, chs_cylinder)
      `CHK("head", 4'(i), chs_head)
      `CHK("xfer", 9'h005, xfer_sectors)
      `CHK("opcode", 8'h30, cmd_opcode)
      pulse(1'b1, 1'b0, '0);
      pulse(1'b1, 1'b0, atf_pkg::atf_exec_err_t'(5'b10000 >> i));
      pulse(1'b0, 1'b1, '0);
      wait_out(1'b1);
      `CHK("err", 1'b1, d2h.status.err)
      if (d2h.status.err === 1'b1) begin
        `CHK("cause", cause_exp[i], d2h.error)
      end
      `CHK("count", 8'h03, d2h.tf.count)
    end
    // A parameter-only frame updates the shadow taskfile and starts nothing.
    snap = starts;
    host.send(1'b0, 8'h20, tf);
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("nocmd", snap, starts)
    `CHK("noanswer", 1'b0, d2h_valid)
    // Refused commands: bad opcode, not ready, write fault.
    for (int j = 0; j < 3; j++) begin
      snap = starts;
      cmd_supported = (j != 0);
      dev_not_ready = (j == 1);
      dev_write_fault = (j == 2);
      host.send(1'b1, 8'hC8, tf);
      wait_out(1'b1);
      `CHK("abort", 8'h04, d2h.error)
      `CHK("err", 1'b1, d2h.status.err)
      `CHK("wfault", (j == 2), d2h.status.write_fault)
      `CHK("refused", snap, starts)
    end
    cmd_supported = 1'b1;
    dev_not_ready = 1'b0;
    dev_write_fault = 1'b0;
    finish_test();
  end
endmodule

/* bench/atf_host_model.sv */
// Host controller model that sends register frames to the taskfile block.
`timescale 1ns/1ps
module atf_host_model (
  input  wire logic         sys_clk,
  output logic              h2d_valid,
  output atf_pkg::atf_h2d_t h2d
);
  // Nothing is offered to the device before the first frame.
  initial begin
    h2d_valid = 1'b0;
    h2d       = '0;
  end

  // frame field transfer
  // Sends one frame for a single cycle, changing fields just after the edge.
  task automatic send(input logic is_cmd, input logic [7:0] op, input atf_pkg::atf_taskfile_t tf);
    @(posedge sys_clk);
    #1;
    h2d.is_command = is_cmd;
    h2d.opcode     = op;
    h2d.tf         = tf;
    h2d.tf.dev_head.fixed7           = 1'b1;
    h2d.tf.dev_head.fixed5           = 1'b1;
    h2d.tf.dev_head.drive_number_bit = 1'b0;
    h2d_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    h2d_valid = 1'b0;
    // Idle fields are scrambled so the device cannot lean on a stale frame.
    h2d = ~h2d;
  endtask
endmodule

/* src/atf_addr_decode.sv */
// Registered decode of the starting address in geometric or linear form.
`timescale 1ns/1ps
`include "atf_params.svh"
module atf_addr_decode (
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire logic                  load,
  input  wire atf_pkg::atf_taskfile_t tf,
  output logic                       linear_mode,
  output logic [27:0]                start_lba,
  output logic [15:0]                chs_cylinder,
  output logic [3:0]                 chs_head,
  output logic [7:0]                 chs_sector
);

  logic [3:0] nibble;

  // Low nibble of drive/head, shared by both addressing forms.
  assign nibble = {tf.dev_head.head_or_addr_bit3, tf.dev_head.head_or_addr_bit2,
                   tf.dev_head.head_or_addr_bit1, tf.dev_head.head_or_addr_bit0};

  // Both forms are captured at command start so the engine sees stable values.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      linear_mode  <= 1'b0;
      start_lba    <= 28'h000_0000;
      chs_cylinder <= 16'h0000;
      chs_head     <= 4'h0;
      chs_sector   <= 8'h00;
    end else if (load) begin
      // RQ15 mode select bit
      linear_mode  <= tf.dev_head.linear_addressing_select;
      // RQ18 join address bytes
      start_lba    <= {nibble, tf.addr2, tf.addr1, tf.addr0};
      // RQ12 RQ13 cylinder bytes
      chs_cylinder <= {tf.addr2, tf.addr1};
      // RQ17 head number nibble
      chs_head     <= nibble;
      // RQ11 starting sector byte
      chs_sector   <= tf.addr0;
    end
  end

  lba_join_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ18
    load |=> start_lba == {$past(nibble), $past(tf.addr2), $past(tf.addr1), $past(tf.addr0)})
    else $error("Linear start address does not match the captured bytes.");

  mode_sel_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ15
    load |=> linear_mode == $past(tf.dev_head.linear_addressing_select) && chs_head == start_lba[27:24])
    else $error("Addressing mode or head nibble was not captured.");

endmodule

/* src/atf_error_address_regs.sv */
// Taskfile error-cause, block count and address registers, exchanged as frame fields.
`timescale 1ns/1ps
`include "atf_params.svh"
module atf_error_address_regs #(
  parameter int CNT_W = 9
) (
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire logic                  h2d_valid,
  input  wire atf_pkg::atf_h2d_t     h2d,
  input  wire logic                  cmd_supported,
  input  wire logic                  dev_not_ready,
  input  wire logic                  dev_write_fault,
  input  wire logic                  exec_sector_done,
  input  wire logic                  exec_done,
  input  wire atf_pkg::atf_exec_err_t exec_err,
  output logic                       d2h_valid,
  output atf_pkg::atf_d2h_t          d2h,
  output logic                       cmd_start,
  output logic [7:0]                 cmd_opcode,
  output logic                       busy,
  output logic [CNT_W-1:0]           xfer_sectors,
  output logic                       linear_mode,
  output logic [27:0]                start_lba,
  output logic [15:0]                chs_cylinder,
  output logic [3:0]                 chs_head,
  output logic [7:0]                 chs_sector
);

  // The remaining counter must hold the 256-sector case.
  generate
    if (CNT_W < `ATF_CNT_W_MIN) begin : g_bad_width
      $error("CNT_W too narrow for a full 256-sector transfer.");
    end
  endgenerate

  atf_pkg::atf_state_t    state_ff;
  atf_pkg::atf_state_t    nxt_state;
  atf_pkg::atf_taskfile_t tf_ff;
  atf_pkg::atf_error_t    error_ff;
  atf_pkg::atf_error_t    nxt_error;
  logic [CNT_W-1:0]       remain_ff;
  logic                   fault_seen_ff;
  logic                   accept;
  logic                   refuse;
  logic                   failed;
  logic [CNT_W-1:0]       full_count;

  // A command frame is taken only while no command is running.
  assign accept = h2d_valid && h2d.is_command && (state_ff != atf_pkg::ATF_EXEC);

  // RQ4 abort at start
  assign refuse = !cmd_supported || dev_not_ready || dev_write_fault;

  // Any cause bit marks the command as failed.
  assign failed = |nxt_error;

  // RQ8 zero means 256
  assign full_count = CNT_W'(atf_pkg::atf_expand_count(h2d.tf.count));

  // Command sequencing: an unsupported or blocked command never enters execution.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      atf_pkg::ATF_IDLE: begin
        if (accept) begin
          nxt_state = refuse ? atf_pkg::ATF_DONE : atf_pkg::ATF_EXEC;
        end
      end
      atf_pkg::ATF_EXEC: begin
        if (exec_done) begin
          nxt_state = atf_pkg::ATF_DONE;
        end
      end
      atf_pkg::ATF_DONE: begin
        if (accept) begin
          nxt_state = refuse ? atf_pkg::ATF_DONE : atf_pkg::ATF_EXEC;
        end else begin
          nxt_state = atf_pkg::ATF_IDLE;
        end
      end
      default: begin
        nxt_state = atf_pkg::ATF_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff <= atf_pkg::ATF_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Error-cause update: a new command clears it; engine events are collected only during execution.
  always_comb begin
    nxt_error = error_ff;
    if (accept) begin
      nxt_error = '0;
      // RQ4 abort cause bit
      nxt_error.command_aborted_flag = refuse;
    end else if (state_ff == atf_pkg::ATF_EXEC) begin
      // RQ1 defective block
      nxt_error.defective_block_flag  = error_ff.defective_block_flag | exec_err.defective_block_flag;
      // RQ2 uncorrectable data
      nxt_error.uncorrectable_flag    = error_ff.uncorrectable_flag | exec_err.uncorrectable_flag;
      // RQ3 sector not found
      nxt_error.sector_not_found_flag = error_ff.sector_not_found_flag | exec_err.sector_not_found_flag;
      // RQ4 aborted in execution
      nxt_error.command_aborted_flag  = error_ff.command_aborted_flag | exec_err.command_aborted_flag;
      // RQ5 general error
      nxt_error.general_error_flag    = error_ff.general_error_flag | exec_err.general_error_flag;
    end
    // RQ7 reserved bits zero
    nxt_error.zero5 = 1'b0;
    nxt_error.zero3 = 1'b0;
    nxt_error.zero1 = 1'b0;
  end

  // Error-cause register; no host path writes it.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      error_ff <= `ATF_RST_BYTE;
    end else begin
      error_ff <= nxt_error;
    end
  end

  // Write fault seen at command start is kept for the status byte of that command.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fault_seen_ff <= 1'b0;
    end else if (accept) begin
      fault_seen_ff <= dev_write_fault;
    end
  end

  // Sectors still owed to the host; frozen once the engine reports completion.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      remain_ff <= CNT_W'(`ATF_RST_REMAIN);
    end else if (accept) begin
      remain_ff <= full_count;
    end else if (state_ff == atf_pkg::ATF_EXEC && exec_sector_done && !exec_done &&
                 remain_ff != '0) begin
      remain_ff <= remain_ff - CNT_W'(1);
    end
  end

  // Shadow taskfile. Host frames are ignored while busy, which is the lock-out.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tf_ff.count    <= `ATF_RST_BYTE;
      tf_ff.addr0    <= `ATF_RST_BYTE;
      tf_ff.addr1    <= `ATF_RST_BYTE;
      tf_ff.addr2    <= `ATF_RST_BYTE;
      tf_ff.dev_head <= `ATF_RST_DEV_HEAD;
    end else if (h2d_valid && state_ff != atf_pkg::ATF_EXEC) begin
      // RQ14 RQ16 stored as written
      tf_ff <= h2d.tf;
    end else if (state_ff == atf_pkg::ATF_EXEC && exec_done) begin
      // RQ9 RQ10 residual count
      tf_ff.count <= failed ? remain_ff[7:0] : 8'h00;
    end
  end

  // Command hand-off to the execution engine.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cmd_start    <= 1'b0;
      cmd_opcode   <= 8'h00;
      xfer_sectors <= '0;
    end else begin
      cmd_start <= accept && !refuse;
      if (accept) begin
        cmd_opcode   <= h2d.opcode;
        // RQ8 full transfer length
        xfer_sectors <= full_count;
      end
    end
  end

  // Busy follows execution; a refused command is never busy.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      busy <= 1'b0;
    end else begin
      busy <= (nxt_state == atf_pkg::ATF_EXEC);
    end
  end

  // Completion frame, sent once from the done state.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      d2h_valid <= 1'b0;
      d2h       <= '0;
    end else begin
      d2h_valid <= (state_ff == atf_pkg::ATF_DONE);
      if (state_ff == atf_pkg::ATF_DONE) begin
        d2h.status              <= '0;
        d2h.status.ready        <= 1'b1;
        d2h.status.seek_done    <= 1'b1;
        d2h.status.write_fault  <= fault_seen_ff;
        // RQ19 RQ6 error summary
        d2h.status.err          <= |error_ff;
        d2h.error               <= error_ff;
        // RQ20 fields in frame
        d2h.tf                  <= tf_ff;
      end
    end
  end

  // Address capture happens with the command so later host frames cannot disturb it.
  atf_addr_decode u_addr_decode (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .load         (accept),
    .tf           (h2d.tf),
    .linear_mode  (linear_mode),
    .start_lba    (start_lba),
    .chs_cylinder (chs_cylinder),
    .chs_head     (chs_head),
    .chs_sector   (chs_sector)
  );

  zero_count_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ8
    accept && !refuse && h2d.tf.count == 8'h00 |=> cmd_start && xfer_sectors == CNT_W'(`ATF_ZERO_COUNT_SECTORS))
    else $error("A zero block count did not request 256 sectors.");

  abort_report_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ4
    accept && !cmd_supported |-> ##2 d2h_valid && d2h.error.command_aborted_flag && d2h.status.err)
    else $error("Unsupported command was not reported as aborted.");

  defect_flag_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ1
    state_ff == atf_pkg::ATF_EXEC && !accept && exec_err.defective_block_flag |=> error_ff.defective_block_flag)
    else $error("Defective block event was not recorded.");

  uncorr_flag_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ2
    state_ff == atf_pkg::ATF_EXEC && exec_err.uncorrectable_flag |=> error_ff.uncorrectable_flag)
    else $error("Uncorrectable event was not recorded.");

  notfound_flag_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ3
    state_ff == atf_pkg::ATF_EXEC && exec_err.sector_not_found_flag |=> error_ff.sector_not_found_flag)
    else $error("Sector not found event was not recorded.");

  general_flag_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ5
    state_ff == atf_pkg::ATF_EXEC && exec_err.general_error_flag |=> error_ff.general_error_flag)
    else $error("General error event was not recorded.");

  reserved_zero_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ7
    !error_ff.zero5 && !error_ff.zero3 && !error_ff.zero1)
    else $error("A reserved error-cause bit is set.");

  success_count_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ9
    d2h_valid && !d2h.status.err |-> d2h.tf.count == 8'h00)
    else $error("Successful completion left a nonzero block count.");

  residual_count_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ10
    d2h_valid && d2h.status.err |-> d2h.tf.count == $past(remain_ff[7:0]))
    else $error("Failed completion did not report the remaining sectors.");

  error_status_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ19
    state_ff == atf_pkg::ATF_DONE |=> d2h_valid && d2h.status.err == (|$past(error_ff)))
    else $error("Status error bit does not match the error-cause register.");

  busy_window_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ20
    state_ff == atf_pkg::ATF_EXEC && exec_done |=> !busy ##1 d2h_valid)
    else $error("Completion frame did not follow the end of execution.");

  start_count_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ8
    accept && !refuse && h2d.tf.count != 8'h00 |=>
    xfer_sectors == CNT_W'($past(h2d.tf.count)))
    else $error("A nonzero block count was not passed on as written.");

  refuse_hold_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ4
    accept && refuse |=>
    !cmd_start && !busy)
    else $error("A refused command reached the engine.");

  notready_abort_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ4
    accept && dev_not_ready |->
    ##2 d2h_valid && d2h.error.command_aborted_flag)
    else $error("A command met while not ready was not aborted.");

  fault_abort_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ4
    accept && dev_write_fault |->
    ##2 d2h_valid && d2h.error.command_aborted_flag && d2h.status.write_fault)
    else $error("A command met during a write fault was not aborted.");

  exec_abort_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ4
    state_ff == atf_pkg::ATF_EXEC && exec_err.command_aborted_flag |=>
    error_ff.command_aborted_flag)
    else $error("An abort during execution was not recorded.");

  cause_clear_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ19
    accept && !refuse |=>
    error_ff == '0)
    else $error("A new command did not clear the error cause.");

  clean_cause_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ6
    d2h_valid && !d2h.status.err |->
    d2h.error == '0)
    else $error("Error cause was set without the status error bit.");

  error_cause_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ6
    d2h_valid && d2h.status.err |->
    d2h.error != '0)
    else $error("Status error bit was set with no error cause.");

  ready_status_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ19
    d2h_valid |->
    d2h.status.ready && d2h.status.seek_done && !d2h.status.busy)
    else $error("Completion status did not report a ready device.");

  frame_fields_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ20
    state_ff == atf_pkg::ATF_DONE |=>
    d2h.tf == $past(tf_ff))
    else $error("Completion frame did not carry the taskfile fields.");

  count_freeze_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ10
    state_ff == atf_pkg::ATF_EXEC && exec_done |=>
    remain_ff == $past(remain_ff))
    else $error("Remaining count moved at the end of execution.");

  count_floor_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ10
    remain_ff == '0 && !accept |=>
    remain_ff == '0)
    else $error("Remaining count wrapped below zero.");

  success_clear_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ9
    state_ff == atf_pkg::ATF_EXEC && exec_done && !failed |=>
    tf_ff.count == 8'h00)
    else $error("A successful command did not clear the block count.");

  busy_level_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ20
    busy ==
    (state_ff == atf_pkg::ATF_EXEC))
    else $error("Busy does not follow execution.");

  frame_lockout_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ20
    h2d_valid && state_ff == atf_pkg::ATF_EXEC && !exec_done |=>
    tf_ff == $past(tf_ff))
    else $error("A host frame changed the taskfile while busy.");

  shadow_store_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ14 RQ16
    h2d_valid && state_ff != atf_pkg::ATF_EXEC |=>
    tf_ff == $past(h2d.tf))
    else $error("A host frame was not stored in the taskfile.");

endmodule

/* src/atf_params.svh */
// Field positions, reset values and fixed counts of the taskfile error and address registers.
`ifndef ATF_PARAMS_SVH
`define ATF_PARAMS_SVH
// What this block does
// RQ1: Error-cause bit 7 is raised when a defective storage block is detected.
// RQ2: Error-cause bit 6 is raised when an uncorrectable data error is met.
// RQ3: Error-cause bit 4 is raised when the requested sector is invalid or missing.
// RQ4: Error-cause bit 2 is raised when a command aborts on status or bad opcode.
// RQ5: Error-cause bit 0 reports a general error not covered by other bits.
// RQ6: Error-cause content only means something while status error bit 0 is set.
// RQ7: Error-cause bits 5, 3 and 1 read zero; the host cannot write it.
// RQ8: A block count of zero requests 256 sectors for reads and writes.
// RQ9: A successful command leaves the block count register at zero.
// RQ10: A failed command leaves the sectors still remaining in the block count register.
// RQ11: Address byte 0 is the starting sector, or linear address bits 7-0.
// RQ12: Address byte 1 is the cylinder low byte, or linear address bits 15-8.
// RQ13: Address byte 2 is the cylinder high byte, or linear address bits 23-16.
// RQ14: The host writes drive/head bits seven and five as one.
// RQ15: Drive/head bit 6 selects geometric (zero) or linear (one) addressing.
// RQ16: The host always writes the drive number bit, bit four, as zero.
// RQ17: Drive/head low nibble is the head number, or linear address bits 27-24.
// RQ18: Linear mode joins low nibble and three address bytes into 28 bits.
// RQ19: Status bit 0 is set when the previous command ended in any error.
// RQ20: Register values travel as frame fields, not over a parallel register bus.

// Error-cause bit positions.
`define ATF_ERR_BIT_DEFECT   7
`define ATF_ERR_BIT_UNCORR   6
`define ATF_ERR_BIT_NOTFOUND 4
`define ATF_ERR_BIT_ABORT    2
`define ATF_ERR_BIT_GENERAL  0

// Status bit positions.
`define ATF_STAT_BIT_BUSY  7
`define ATF_STAT_BIT_READY 6
`define ATF_STAT_BIT_WF    5
`define ATF_STAT_BIT_DSC   4
`define ATF_STAT_BIT_ERR   0

// Drive/head bit positions.
`define ATF_DH_BIT_LINEAR 6
`define ATF_DH_BIT_DRIVE  4

// Counts and reset values.
`define ATF_ZERO_COUNT_SECTORS 9'h100
`define ATF_CNT_W_MIN          9
`define ATF_RST_BYTE           8'h00
`define ATF_RST_DEV_HEAD       8'hA0
`define ATF_RST_REMAIN         9'h000
`endif

/* src/atf_pkg.sv */
// Types shared by the taskfile register block and its address decoder.
`include "atf_params.svh"
package atf_pkg;

  // Error-cause layout; the zero fields are never set.
  typedef struct packed {
    logic defective_block_flag;
    logic uncorrectable_flag;
    logic zero5;
    logic sector_not_found_flag;
    logic zero3;
    logic command_aborted_flag;
    logic zero1;
    logic general_error_flag;
  } atf_error_t;

  // Status byte as returned to the host.
  typedef struct packed {
    logic busy;
    logic ready;
    logic write_fault;
    logic seek_done;
    logic data_request;
    logic corrected;
    logic index;
    logic err;
  } atf_status_t;

  // Drive/head byte.
  typedef struct packed {
    logic fixed7;
    logic linear_addressing_select;
    logic fixed5;
    logic drive_number_bit;
    logic head_or_addr_bit3;
    logic head_or_addr_bit2;
    logic head_or_addr_bit1;
    logic head_or_addr_bit0;
  } atf_dev_head_t;

  // Command-block fields carried in a register frame.
  typedef struct packed {
    logic [7:0]    count;
    logic [7:0]    addr0;
    logic [7:0]    addr1;
    logic [7:0]    addr2;
    atf_dev_head_t dev_head;
  } atf_taskfile_t;

  // Host-to-device register frame fields.
  typedef struct packed {
    logic          is_command;
    logic [7:0]    opcode;
    atf_taskfile_t tf;
  } atf_h2d_t;

  // Device-to-host register frame fields.
  typedef struct packed {
    atf_status_t   status;
    atf_error_t    error;
    atf_taskfile_t tf;
  } atf_d2h_t;

  // Error events reported by the execution engine.
  typedef struct packed {
    logic defective_block_flag;
    logic uncorrectable_flag;
    logic sector_not_found_flag;
    logic command_aborted_flag;
    logic general_error_flag;
  } atf_exec_err_t;

  typedef enum logic [1:0] {ATF_IDLE, ATF_EXEC, ATF_DONE} atf_state_t;

  // A zero block count stands for the largest transfer.
  function automatic logic [8:0] atf_expand_count(input logic [7:0] cnt);
    atf_expand_count = (cnt == 8'h00) ? `ATF_ZERO_COUNT_SECTORS : {1'b0, cnt};
  endfunction

endpackage
